// ==== src/sbcf_parser.sv ====
// Parser of the slot-level time-domain beam configuration command, with AXI4-Lite registers.
// What this block does
// - Eight-octet transport header, then section header from the ninth octet.
// - Command header from octet 17; symbol mask body starts at octet 25.
// - Weight-disabled entries carry only beam numbers, no parameters nor weights.
// - Each entry starts with two octets: weight flag, then fifteen-bit beam number.
// - With weights, each entry is zero padded to a four-byte boundary.
// - Without weights, padding occurs once, after the last beam entry.
// - Disable bit precedes the beam group; set means group only.
// - Mask bits before the first symbol index are ignored.
`timescale 1ns/1ps
`include "sbcf_regs.svh"
module sbcf_parser
	import sbcf_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_last_i,
	output logic             beam_valid_o,
	output logic      [14:0] beam_number_o,
	output logic             beam_weight_disable_o,
	output logic             msg_done_o,
	output logic             msg_error_o,
	output logic      [13:0] symbol_apply_mask_o,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp
);
	sbcf_state_t state;
	sbcf_state_t next_state;
	logic [15:0] byte_idx;
	logic [15:0] nidx;
	logic [7:0]  cmd_type;
	logic [5:0]  first_symbol_index;
	logic [13:0] mask_raw;
	logic [13:0] mask_keep;
	logic        beam_number_disable;
	logic [14:0] time_beam_group;
	logic [7:0]  weight_compression_header;
	logic        weight_disable;
	logic [6:0]  beam_hi;
	logic [7:0]  beam_cnt;
	logic [7:0]  wgt_cnt;
	logic        last_entry;
	logic [7:0]  cfg_beams;
	logic [7:0]  cfg_wlen;
	logic [7:0]  tbl_idx;
	logic [15:0] tbl_rdata;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic        take_byte;
	logic        msg_ok;

	assign take_byte = rx_valid_i;
	assign nidx = byte_idx + 16'h0001;
	assign last_entry = (beam_cnt + 8'h01) == cfg_beams;
	assign mask_keep = ~((14'h0001 << first_symbol_index) - 14'h0001);

	always_comb begin
		next_state = state;
		case (state)
			S_HDR: if (byte_idx == `SBCF_HDR_LAST) next_state = S_MASK_HI;
			S_MASK_HI: next_state = S_MASK_LO;
			S_MASK_LO: next_state = S_GRP_HI;
			S_GRP_HI: next_state = S_GRP_LO;
			S_GRP_LO: next_state = S_CHDR;
			S_CHDR: next_state = S_RSV;
			S_RSV: begin
				if (byte_idx == `SBCF_RSV_LAST) begin
					next_state = (beam_number_disable || cfg_beams == 8'h00) ? S_DONE : S_BEAM_HI;
				end
			end
			S_BEAM_HI: next_state = S_BEAM_LO;
			S_BEAM_LO: begin
				if (!weight_disable && cfg_wlen != 8'h00) begin
					next_state = S_WGT;
				end else if (weight_disable && !last_entry) begin
					next_state = S_BEAM_HI;
				end else if ((nidx[1:0] & `SBCF_ALIGN_MASK) != 2'h0) begin
					next_state = S_PAD;
				end else begin
					next_state = last_entry ? S_DONE : S_BEAM_HI;
				end
			end
			S_WGT: begin
				if (wgt_cnt == 8'h01) begin
					if ((nidx[1:0] & `SBCF_ALIGN_MASK) != 2'h0) next_state = S_PAD;
					else next_state = (beam_cnt == cfg_beams) ? S_DONE : S_BEAM_HI;
				end
			end
			S_PAD: begin
				if ((nidx[1:0] & `SBCF_ALIGN_MASK) == 2'h0) begin
					next_state = (beam_cnt == cfg_beams) ? S_DONE : S_BEAM_HI;
				end
			end
			S_DONE: next_state = S_DONE;
			default: next_state = S_HDR;
		endcase
	end

	assign msg_ok = (next_state == S_DONE) && (cmd_type == `SBCF_CMD_BEAM);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= S_HDR;
			byte_idx <= 16'h0000;
		end else if (take_byte && rx_last_i) begin
			state <= S_HDR;
			byte_idx <= 16'h0000;
		end else if (take_byte) begin
			state <= next_state;
			byte_idx <= nidx;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_type <= 8'h00;
			first_symbol_index <= 6'h00;
			mask_raw <= 14'h0000;
			beam_number_disable <= 1'b0;
			time_beam_group <= 15'h0000;
			weight_compression_header <= 8'h00;
		end else if (take_byte) begin
			if (state == S_HDR && byte_idx == `SBCF_CMD_TYPE_POS) cmd_type <= rx_data_i;
			if (state == S_HDR && byte_idx == `SBCF_FIRST_SYM_POS) begin
				first_symbol_index <= rx_data_i[5:0];
			end
			if (state == S_MASK_HI) mask_raw[13:8] <= rx_data_i[5:0];
			if (state == S_MASK_LO) mask_raw[7:0] <= rx_data_i;
			if (state == S_GRP_HI) begin
				beam_number_disable <= rx_data_i[7];
				time_beam_group[14:8] <= rx_data_i[6:0];
			end
			if (state == S_GRP_LO) time_beam_group[7:0] <= rx_data_i;
			if (state == S_CHDR) weight_compression_header <= rx_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			weight_disable <= 1'b0;
			beam_hi <= 7'h00;
			beam_cnt <= 8'h00;
			wgt_cnt <= 8'h00;
		end else if (take_byte && rx_last_i) begin
			beam_cnt <= 8'h00;
		end else if (take_byte) begin
			if (state == S_BEAM_HI) begin
				weight_disable <= rx_data_i[7];
				beam_hi <= rx_data_i[6:0];
			end
			if (state == S_BEAM_LO) begin
				beam_cnt <= beam_cnt + 8'h01;
				wgt_cnt <= cfg_wlen;
			end
			if (state == S_WGT) wgt_cnt <= wgt_cnt - 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			beam_valid_o <= 1'b0;
			beam_number_o <= 15'h0000;
			beam_weight_disable_o <= 1'b0;
			msg_done_o <= 1'b0;
			msg_error_o <= 1'b0;
			symbol_apply_mask_o <= 14'h0000;
		end else begin
			beam_valid_o <= take_byte && state == S_BEAM_LO;
			if (take_byte && state == S_BEAM_LO) begin
				beam_number_o <= {beam_hi, rx_data_i};
				beam_weight_disable_o <= weight_disable;
			end
			msg_done_o <= take_byte && rx_last_i;
			if (take_byte && rx_last_i) msg_error_o <= !msg_ok;
			symbol_apply_mask_o <= mask_raw & mask_keep;
		end
	end

	sbcf_beam_mem u_mem (
		.clk_sys_i (clk_sys_i),
		.wr_en_i   (take_byte && state == S_BEAM_LO),
		.wr_addr_i (beam_cnt),
		.wr_data_i ({weight_disable, beam_hi, rx_data_i}),
		.rd_addr_i (tbl_idx),
		.rd_data_o (tbl_rdata)
	);

	// Address and data are held separately so the master may offer them in either order.
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SBCF_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `SBCF_ADDR_CFG || aw_addr == `SBCF_ADDR_TBL_IDX)
					? `SBCF_RESP_OKAY : `SBCF_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_beams <= `SBCF_BEAMS_RST;
			cfg_wlen <= `SBCF_WLEN_RST;
			tbl_idx <= 8'h00;
		end else if (do_write) begin
			if (aw_addr == `SBCF_ADDR_CFG) begin
				if (w_strb[0]) cfg_beams <= w_data[7:0];
				if (w_strb[1]) cfg_wlen <= w_data[15:8];
			end else if (aw_addr == `SBCF_ADDR_TBL_IDX) begin
				if (w_strb[0]) tbl_idx <= w_data[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SBCF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SBCF_RESP_OKAY;
			if (s_axi_araddr == `SBCF_ADDR_CFG) begin
				s_axi_rdata <= {16'h0000, cfg_wlen, cfg_beams};
			end else if (s_axi_araddr == `SBCF_ADDR_STATUS) begin
				s_axi_rdata <= {8'h00, beam_cnt, cmd_type, 6'h00, msg_error_o, state == S_DONE};
			end else if (s_axi_araddr == `SBCF_ADDR_MASK) begin
				s_axi_rdata <= {10'h000, first_symbol_index, 2'h0, symbol_apply_mask_o};
			end else if (s_axi_araddr == `SBCF_ADDR_GROUP) begin
				s_axi_rdata <= {8'h00, weight_compression_header, beam_number_disable,
					time_beam_group};
			end else if (s_axi_araddr == `SBCF_ADDR_TBL_IDX) begin
				s_axi_rdata <= {24'h000000, tbl_idx};
			end else if (s_axi_araddr == `SBCF_ADDR_TBL_DATA) begin
				s_axi_rdata <= {16'h0000, tbl_rdata};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `SBCF_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	sequence beam_lo_taken;
		take_byte && !rx_last_i && state == S_BEAM_LO;
	endsequence

	a_mask_body_start: assert property (
		(take_byte && state == S_MASK_LO) |=> mask_raw[7:0] == $past(rx_data_i))
		else $error("Mask low octet misread.");
	a_header_skip: assert property (
		(state == S_MASK_HI) |-> byte_idx == `SBCF_MASK_POS)
		else $error("Header length wrong.");
	a_group_place: assert property (
		(state == S_GRP_HI) |-> byte_idx == `SBCF_GRP_POS)
		else $error("Beam group misplaced.");
	a_entry_out: assert property (
		beam_lo_taken |=> beam_valid_o && beam_number_o == {$past(beam_hi), $past(rx_data_i)})
		else $error("Beam entry not emitted.");
	a_no_weights: assert property (
		(beam_lo_taken and weight_disable) |=> state != S_WGT)
		else $error("Weights parsed though disabled.");
	a_pad_align: assert property (
		(take_byte && !rx_last_i && state == S_PAD && next_state != S_PAD)
		|=> byte_idx[1:0] == 2'h0) else $error("Padding ends off boundary.");
	a_pad_once: assert property (
		(state == S_PAD && weight_disable) |-> beam_cnt == cfg_beams)
		else $error("Padding between unweighted entries.");
	a_early_masked: assert property (
		((symbol_apply_mask_o & ~mask_keep) == 14'h0000) || $changed(first_symbol_index))
		else $error("Early symbol bit left set.");
	a_resv_ignored: assert property (
		(take_byte && state == S_MASK_HI) |=> mask_raw[13:8] == $past(rx_data_i[5:0]))
		else $error("Mask high octet misread.");
	a_bresp_hold: assert property (
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("Write response dropped.");
endmodule : sbcf_parser

// ==== src/sbcf_regs.svh ====
// Byte positions, register offsets and reset values of the beam configuration parser.
`ifndef SBCF_REGS_SVH
`define SBCF_REGS_SVH
`define SBCF_FIRST_SYM_POS 16'h000b
`define SBCF_CMD_TYPE_POS  16'h0010
`define SBCF_HDR_LAST      16'h0017
`define SBCF_MASK_POS      16'h0018
`define SBCF_GRP_POS       16'h001a
`define SBCF_RSV_LAST      16'h001f
`define SBCF_CMD_BEAM      8'h01
`define SBCF_ALIGN_MASK    2'h3
`define SBCF_ADDR_CFG      8'h00
`define SBCF_ADDR_STATUS   8'h04
`define SBCF_ADDR_MASK     8'h08
`define SBCF_ADDR_GROUP    8'h0c
`define SBCF_ADDR_TBL_IDX  8'h10
`define SBCF_ADDR_TBL_DATA 8'h14
`define SBCF_BEAMS_RST     8'h01
`define SBCF_WLEN_RST      8'h00
`define SBCF_RESP_OKAY     2'h0
`define SBCF_RESP_SLVERR   2'h2
`endif

// ==== src/sbcf_pkg.sv ====
// Types shared by the beam configuration parser.
package sbcf_pkg;
	typedef enum logic [11:0] {
		S_HDR     = 12'h001,
		S_MASK_HI = 12'h002,
		S_MASK_LO = 12'h004,
		S_GRP_HI  = 12'h008,
		S_GRP_LO  = 12'h010,
		S_CHDR    = 12'h020,
		S_RSV     = 12'h040,
		S_BEAM_HI = 12'h080,
		S_BEAM_LO = 12'h100,
		S_WGT     = 12'h200,
		S_PAD     = 12'h400,
		S_DONE    = 12'h800
	} sbcf_state_t;
endpackage : sbcf_pkg

// ==== src/sbcf_beam_mem.sv ====
// Beam entry table with a registered read port.
`timescale 1ns/1ps
module sbcf_beam_mem (
	input  wire logic        clk_sys_i,
	input  wire logic        wr_en_i,
	input  wire logic [7:0]  wr_addr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic [7:0]  rd_addr_i,
	output logic      [15:0] rd_data_o
);
	logic [15:0] mem [0:255];

	always_ff @(posedge clk_sys_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		rd_data_o <= mem[rd_addr_i];
	end
endmodule : sbcf_beam_mem

// ==== dv/sbcf_du_model.sv ====
// Model of the sending unit that builds and streams beam configuration commands.
`timescale 1ns/1ps
module sbcf_du_model (
	input  wire logic       clk_sys_i,
	output logic            rx_valid_o,
	output logic      [7:0] rx_data_o,
	output logic            rx_last_o
);
	logic [7:0] msg [0:63];
	int         len;
	logic [7:0] rsv = 8'h00;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
		rx_last_o  = 1'b0;
	end
	task automatic build(input logic [7:0] cmd, input int nb, input int wlen, input logic gdis,
		input logic [13:0] m, input logic [5:0] fs, input int cut);
		int n;
		for (int i = 0; i < 64; i++) begin
			msg[i] = 8'h00;
		end
		msg[11] = {2'h0, fs};
		msg[16] = cmd;
		// leading mask bits
		// Leading bits may be sent set so that the receiver has something to ignore.
		msg[24] = {rsv[7:6], m[13:8]};
		msg[25] = m[7:0];
		msg[26] = {gdis, 7'h01};
		msg[27] = 8'h23;
		// reserved octets
		// Reserved octets may carry junk on request to prove that the receiver drops them.
		for (int r = 29; r < 32; r++) begin
			msg[r] = rsv;
		end
		n = 32;
		for (int b = 0; b < nb && !gdis; b++) begin
			msg[n] = {wlen == 0, 7'h2a};
			msg[n+1] = 8'h10 + 8'(b);
			n += 2;
			for (int w = 0; w < wlen; w++) begin
				msg[n+w] = 8'ha5;
			end
			n += wlen;
			while (wlen != 0 && n % 4 != 0) n++;
		end
		while (n % 4 != 0) n++;
		len = (cut > 0) ? cut : n + 1;
	endtask : build
	task automatic send();
		for (int i = 0; i < len; i++) begin
			@(posedge clk_sys_i);
			rx_valid_o <= 1'b1;
			rx_data_o  <= msg[i];
			rx_last_o  <= (i == len - 1);
		end
		@(posedge clk_sys_i);
		rx_valid_o <= 1'b0;
		rx_data_o  <= ~msg[len-1];
		rx_last_o  <= 1'b0;
	endtask : send
endmodule : sbcf_du_model

// ==== dv/testbench.sv ====
// Self-checking bench of the beam configuration parser.
`timescale 1ns/1ps
`include "sbcf_regs.svh"
module testbench;
	logic        clk_sys_i, nrst_i, rx_valid, rx_last, beam_valid, beam_wdis, msg_done, msg_error;
	logic [7:0]  rx_data, awaddr, araddr;
	logic [14:0] beam_number;
	logic [13:0] mask;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	int          error_cnt, compares, nbeam, ndone;
	sbcf_du_model du (.clk_sys_i(clk_sys_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.rx_last_o(rx_last));
	sbcf_parser DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rx_valid_i(rx_valid),
		.rx_data_i(rx_data), .rx_last_i(rx_last), .beam_valid_o(beam_valid),
		.beam_number_o(beam_number), .beam_weight_disable_o(beam_wdis), .msg_done_o(msg_done),
		.msg_error_o(msg_error), .symbol_apply_mask_o(mask), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (beam_valid === 1'b1) nbeam++;
		if (msg_done === 1'b1) ndone++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_sys_i);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hf;
		bready  <= 1'b1;
		do begin
			@(negedge clk_sys_i);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rsp = bresp;
			@(posedge clk_sys_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (tb !== 1'b1);
		bready <= 1'b0;
		chk(32'(rsp), 32'(`SBCF_RESP_OKAY), "write response");
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge clk_sys_i);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do begin
			@(negedge clk_sys_i);
			ta = arvalid & arready;
			tr = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge clk_sys_i);
			if (ta) arvalid <= 1'b0;
		end while (tr !== 1'b1);
		rready <= 1'b0;
	endtask : axi_rd
	// Streams one message and judges the done pulse, entry count and error flag.
	task automatic run_msg(input logic [7:0] cmd, input int nb, input int wlen, input logic gdis,
		input logic [13:0] m, input logic [5:0] fs, input int cut, input int eb, input logic ee);
		int b0, d0, t;
		b0 = nbeam;
		d0 = ndone;
		t = 0;
		du.build(cmd, nb, wlen, gdis, m, fs, cut);
		du.send();
		while (ndone == d0 && t < 10) begin
			@(posedge clk_sys_i);
			t++;
		end
		@(negedge clk_sys_i);
		chk(32'(ndone - d0), 32'h1, "done count");
		if (eb >= 0) chk(32'(nbeam - b0), 32'(eb), "entry count");
		chk(32'(msg_error), 32'(ee), "error flag");
	endtask : run_msg
	task automatic t_regs();
		axi_rd(`SBCF_ADDR_CFG);
		chk(rd, 32'h0000_0001, "cfg reset");
		axi_rd(8'h40);
		chk(rd, 32'h0, "unmapped data");
		chk(32'(rsp), 32'(`SBCF_RESP_SLVERR), "unmapped resp");
		$display("test regs done");
	endtask : t_regs
	task automatic t_plain();
		axi_wr(`SBCF_ADDR_CFG, 32'h0000_0003);
		run_msg(8'h01, 3, 0, 1'b0, 14'h3fff, 6'h03, 0, 3, 1'b0);
		chk(32'(beam_number), 32'h2a12, "beam number");
		chk(32'(beam_wdis), 32'h1, "weight flag");
		chk(32'(mask), 32'h3ff8, "mask");
		axi_rd(`SBCF_ADDR_GROUP);
		chk(rd, 32'h0000_0123, "group");
		axi_wr(`SBCF_ADDR_TBL_IDX, 32'h0000_0002);
		axi_rd(`SBCF_ADDR_TBL_DATA);
		chk(rd, 32'h0000_aa12, "stored entry");
		$display("test plain done");
	endtask : t_plain
	task automatic t_weighted();
		axi_wr(`SBCF_ADDR_CFG, 32'h0000_0302);
		run_msg(8'h01, 2, 3, 1'b0, 14'h0f0f, 6'h00, 0, 2, 1'b0);
		chk(32'(beam_number), 32'h2a11, "beam number");
		chk(32'(beam_wdis), 32'h0, "weight flag");
		chk(32'(mask), 32'h0f0f, "mask");
		$display("test weighted done");
	endtask : t_weighted
	task automatic t_group();
		du.rsv = 8'hff;
		run_msg(8'h01, 2, 0, 1'b1, 14'h00ff, 6'h00, 0, 0, 1'b0);
		du.rsv = 8'h00;
		chk(32'(mask), 32'h00ff, "mask with reserved set");
		axi_rd(`SBCF_ADDR_GROUP);
		chk(rd, 32'h0000_8123, "group only");
		$display("test group done");
	endtask : t_group
	task automatic t_errors();
		run_msg(8'h02, 2, 3, 1'b0, 14'h0001, 6'h00, 0, -1, 1'b1);
		run_msg(8'h01, 2, 3, 1'b0, 14'h0001, 6'h00, 30, 0, 1'b1);
		axi_rd(`SBCF_ADDR_STATUS);
		chk(rd & 32'h2, 32'h2, "status error");
		$display("test errors done");
	endtask : t_errors
	task automatic close_out();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	initial begin
		#(40 * 20000);
		error_cnt++;
		close_out();
	end
	initial begin
		{nrst_i, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (16) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		t_regs();
		t_plain();
		t_weighted();
		t_group();
		t_errors();
		close_out();
	end
endmodule : testbench
